// file: pkg/spm_pkg.sv
// package: constants for the serial port pad multiplexer
package spm_pkg;
   localparam int SPM_PE_SCLK_BIT = 4;
   localparam int SPM_PE_MOSI_BIT = 5;
   localparam int SPM_PE_MISO_BIT = 6;
   localparam int SPM_PE_SS_BIT = 7;
   localparam int SPM_PC_PHA_BIT = 0;
   localparam logic [7:0] SPM_PE_PUR_RST = 8'hF0;
   localparam logic [7:0] SPM_PC_PUR_RST = 8'hFF;
   localparam logic [7:0] SPM_PE_GPS_RST = 8'h00;
   localparam logic SPM_PHA_ALT_RST = 1'b0;
   localparam logic SPM_TMR_SEL_RST = 1'b0;
   localparam logic SPM_CFGD_RST = 1'b0;
   // shared phase-a pad function
   typedef enum logic [1:0] {SPM_FN_NONE, SPM_FN_PHASE, SPM_FN_TIMER, SPM_FN_SCLK} spm_fn_t;
endpackage

// file: logic/spm_pad_mux.sv
// module: pad multiplexing and pull-up control for the serial port pins
`timescale 1ns/1ps
module spm_pad_mux
   import spm_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // software writes: gpio select (1 = gpio), pull-up enables and shared pad selects
   input wire logic cfg_we,
   input wire logic [7:0] cfg_port_e_gpio_sel,
   input wire logic pur_e_we,
   input wire logic [7:0] port_e_pullup_enable,
   input wire logic pur_c_we,
   input wire logic [7:0] port_c_pullup_enable,
   input wire logic alt_we,
   input wire logic phase_a_alternate_select,
   input wire logic tmr_sel_we,
   input wire logic tmr_sel,
   // port e gpio logic, bits 4..7
   input wire logic [3:0] gpio_e_oe,
   input wire logic [3:0] gpio_e_out,
   output logic [3:0] gpio_e_in,
   // port c gpio bit 0
   input wire logic gpio_c0_oe,
   input wire logic gpio_c0_out,
   output logic gpio_c0_in,
   // serial controller 0
   input wire logic spi0_master,
   input wire logic spi0_sclk_out,
   input wire logic spi0_mosi_out,
   input wire logic spi0_miso_out,
   output logic spi0_sclk_in,
   output logic spi0_mosi_in,
   output logic spi0_miso_in,
   output logic spi0_selected,
   // serial controller 1 clock
   input wire logic spi1_master,
   input wire logic spi1_sclk_out,
   output logic spi1_sclk_in,
   // quadrature and timer side of the shared pad
   output logic decoder1_phase_a,
   input wire logic timer_b_channel0_oe,
   input wire logic timer_b_channel0_out,
   output logic timer_b_channel0_in,
   // port0 pads
   input wire logic port0_serial_clock_i,
   output logic port0_serial_clock_o,
   output logic port0_serial_clock_oe,
   output logic port0_serial_clock_pu,
   input wire logic port0_master_out_i,
   output logic port0_master_out_o,
   output logic port0_master_out_oe,
   output logic port0_master_out_pu,
   input wire logic port0_master_in_i,
   output logic port0_master_in_o,
   output logic port0_master_in_oe,
   output logic port0_master_in_pu,
   input wire logic port0_slave_select_n_i,
   output logic port0_slave_select_n_o,
   output logic port0_slave_select_n_oe,
   output logic port0_slave_select_n_pu,
   // shared phase-a pad
   input wire logic port_c_bit0_i,
   output logic port_c_bit0_o,
   output logic port_c_bit0_oe,
   output logic port_c_bit0_pu,
   // current function of the shared pad
   output spm_fn_t pha_fn
);
   // gpio select of the four port0 pads, 1 = gpio, bit 0 = clock .. bit 3 = select
   logic [3:0] gsel_r;
   logic [3:0] gsel_nxt;
   // pull-up enables of the four port0 pads, same bit order
   logic [3:0] pue_r;
   logic [3:0] pue_nxt;
   // pull-up enable of the shared phase-a pad
   logic puc_r;
   logic puc_nxt;
   // shared pad selects; cfgd_r records that software has picked a function
   logic alt_r;
   logic alt_nxt;
   logic tsel_r;
   logic tsel_nxt;
   logic cfgd_r;
   logic cfgd_nxt;
   // serial roles of the port0 pads
   logic sclk_serial;
   logic mosi_serial;
   logic miso_serial;
   logic ss_serial;
   logic spi0_slave;

   // gpio select group
   always_comb begin
      gsel_nxt = gsel_r;
      if (cfg_we) begin
         gsel_nxt = cfg_port_e_gpio_sel[SPM_PE_SS_BIT:SPM_PE_SCLK_BIT];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         gsel_r <= SPM_PE_GPS_RST[SPM_PE_SS_BIT:SPM_PE_SCLK_BIT];
      end else begin
         gsel_r <= gsel_nxt;
      end
   end

   // port e pull-up group; a cleared bit turns that pad's pull-up off
   always_comb begin
      pue_nxt = pue_r;
      if (pur_e_we) begin
         pue_nxt = port_e_pullup_enable[SPM_PE_SS_BIT:SPM_PE_SCLK_BIT];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pue_r <= SPM_PE_PUR_RST[SPM_PE_SS_BIT:SPM_PE_SCLK_BIT];
      end else begin
         pue_r <= pue_nxt;
      end
   end

   // port c pull-up group, shared pad only
   always_comb begin
      puc_nxt = puc_r;
      if (pur_c_we) begin
         puc_nxt = port_c_pullup_enable[SPM_PC_PHA_BIT];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         puc_r <= SPM_PC_PUR_RST[SPM_PC_PHA_BIT];
      end else begin
         puc_r <= puc_nxt;
      end
   end

   // shared pad select group; a write to either select marks the pad as configured
   always_comb begin
      alt_nxt = alt_r;
      tsel_nxt = tsel_r;
      cfgd_nxt = cfgd_r;
      if (alt_we) begin
         alt_nxt = phase_a_alternate_select;
         cfgd_nxt = 1'b1;
      end
      if (tmr_sel_we) begin
         tsel_nxt = tmr_sel;
         cfgd_nxt = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         alt_r <= SPM_PHA_ALT_RST;
         tsel_r <= SPM_TMR_SEL_RST;
         cfgd_r <= SPM_CFGD_RST;
      end else begin
         alt_r <= alt_nxt;
         tsel_r <= tsel_nxt;
         cfgd_r <= cfgd_nxt;
      end
   end

   // role decode: a pad serves the serial controller while its gpio select is clear
   always_comb begin
      sclk_serial = !gsel_r[0];
      mosi_serial = !gsel_r[1];
      miso_serial = !gsel_r[2];
      ss_serial = !gsel_r[3];
      spi0_slave = !spi0_master;
   end

   // shared pad function; timing of data vs clock is the controller's job
   always_comb begin
      if (alt_r) begin
         pha_fn = SPM_FN_SCLK;
      end else if (tsel_r) begin
         pha_fn = SPM_FN_TIMER;
      end else if (LARGE_VARIANT || cfgd_r) begin
         pha_fn = SPM_FN_PHASE;
      end else begin
         pha_fn = SPM_FN_NONE;
      end
   end

   // pull-ups follow their enable bits whatever the pad's function
   always_comb begin
      port0_serial_clock_pu = pue_r[0];
      port0_master_out_pu = pue_r[1];
      port0_master_in_pu = pue_r[2];
      port0_slave_select_n_pu = pue_r[3];
   end

   // pad levels toward the controller; a pad in gpio use reads as 0 so that
   // a stray level on it cannot start a transfer
   always_comb begin
      gpio_e_in = {port0_slave_select_n_i, port0_master_in_i, port0_master_out_i, port0_serial_clock_i};
      spi0_sclk_in = sclk_serial ? port0_serial_clock_i : 1'b0;
      spi0_mosi_in = mosi_serial ? port0_master_out_i : 1'b0;
      spi0_miso_in = miso_serial ? port0_master_in_i : 1'b0;
      spi0_selected = ss_serial && spi0_slave && !port0_slave_select_n_i;
   end

   // clock pad: driven by a master, an input to a slave
   always_comb begin
      if (sclk_serial) begin
         port0_serial_clock_oe = spi0_master;
         port0_serial_clock_o = spi0_sclk_out;
      end else begin
         port0_serial_clock_oe = gpio_e_oe[0];
         port0_serial_clock_o = gpio_e_out[0];
      end
   end

   // master-out pad: data passes straight through so the controller's half-period lead is kept
   always_comb begin
      if (mosi_serial) begin
         port0_master_out_oe = spi0_master;
         port0_master_out_o = spi0_mosi_out;
      end else begin
         port0_master_out_oe = gpio_e_oe[1];
         port0_master_out_o = gpio_e_out[1];
      end
   end

   // master-in pad: in serial use driven only by a selected slave, otherwise left undriven
   // so that another selected slave can own the line
   always_comb begin
      if (miso_serial) begin
         port0_master_in_oe = spi0_selected;
         port0_master_in_o = spi0_miso_out;
      end else begin
         port0_master_in_oe = gpio_e_oe[2];
         port0_master_in_o = gpio_e_out[2];
      end
   end

   // select pad: always an input in serial use
   always_comb begin
      if (ss_serial) begin
         port0_slave_select_n_oe = 1'b0;
         port0_slave_select_n_o = 1'b0;
      end else begin
         port0_slave_select_n_oe = gpio_e_oe[3];
         port0_slave_select_n_o = gpio_e_out[3];
      end
   end

   // shared pad inputs: gpio always sees the pad, the other consumers only while they own it
   always_comb begin
      gpio_c0_in = port_c_bit0_i;
      decoder1_phase_a = (pha_fn == SPM_FN_PHASE) ? port_c_bit0_i : 1'b0;
      timer_b_channel0_in = (pha_fn == SPM_FN_TIMER) ? port_c_bit0_i : 1'b0;
      spi1_sclk_in = (pha_fn == SPM_FN_SCLK) ? port_c_bit0_i : 1'b0;
   end

   // shared pad drive and pull-up
   always_comb begin
      port_c_bit0_pu = puc_r;
      case (pha_fn)
         SPM_FN_SCLK: begin
            port_c_bit0_oe = spi1_master;
            port_c_bit0_o = spi1_sclk_out;
         end
         SPM_FN_TIMER: begin
            port_c_bit0_oe = timer_b_channel0_oe;
            port_c_bit0_o = timer_b_channel0_out;
         end
         SPM_FN_PHASE: begin
            // the phase input never drives the pad
            port_c_bit0_oe = 1'b0;
            port_c_bit0_o = 1'b0;
         end
         default: begin
            port_c_bit0_oe = gpio_c0_oe;
            port_c_bit0_o = gpio_c0_out;
         end
      endcase
   end
endmodule

// file: tb/spm_pad_mux_checker.sv
// assertion checker for the serial port pad multiplexer
`timescale 1ns/1ps
module spm_pad_mux_checker
   import spm_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // clock, reset, configuration
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_port_e_gpio_sel,
   input wire logic pur_e_we,
   input wire logic [7:0] port_e_pullup_enable,
   input wire logic pur_c_we,
   input wire logic [7:0] port_c_pullup_enable,
   input wire logic port_c_bit0_pu,
   input wire logic alt_we,
   input wire logic phase_a_alternate_select,
   // serial and gpio side
   input wire logic spi0_master,
   input wire logic spi0_selected,
   input wire logic [3:0] gpio_e_oe,
   // pads
   input wire logic port0_slave_select_n_i,
   input wire logic port0_serial_clock_oe,
   input wire logic port0_serial_clock_pu,
   input wire logic port0_master_out_oe,
   input wire logic port0_master_out_pu,
   input wire logic port0_master_in_oe,
   input wire logic port0_master_in_pu,
   input wire logic port0_slave_select_n_oe,
   input wire logic port0_slave_select_n_pu,
   input spm_fn_t pha_fn
);
   logic [3:0] gsel_r;
   logic [3:0] gsel_nxt;
   wire [3:0] oe4 = {port0_slave_select_n_oe, port0_master_in_oe, port0_master_out_oe, port0_serial_clock_oe};
   wire [3:0] pu4 = {port0_slave_select_n_pu, port0_master_in_pu, port0_master_out_pu, port0_serial_clock_pu};
   // shadow of the gpio select, 1 = gpio
   always_comb gsel_nxt = cfg_we ? cfg_port_e_gpio_sel[7:4] : gsel_r;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) gsel_r <= 4'h0;
      else gsel_r <= gsel_nxt;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_alt_set;
      alt_we && phase_a_alternate_select;
   endsequence
   a_clk_mosi_dir: assert property (gsel_r[1:0] == 2'h0 |-> oe4[1:0] == {2{spi0_master}})
      else $error("clock or master-out direction wrong");
   a_miso_dir: assert property (!gsel_r[2] && spi0_master |-> !port0_master_in_oe)
      else $error("master-in driven as master");
   a_miso_hiz: assert property (gsel_r[3:2] == 2'h0 && !spi0_master && port0_slave_select_n_i |-> !oe4[2])
      else $error("master-in driven while unselected");
   a_sel_flag: assert property (!gsel_r[3] && !spi0_master && !port0_slave_select_n_i |-> spi0_selected)
      else $error("select not passed on");
   a_gpio_own: assert property (gsel_r == 4'hF |-> oe4 == gpio_e_oe)
      else $error("gpio enable not followed");
   a_pullup_e: assert property (pur_e_we |=> pu4 == $past(port_e_pullup_enable[7:4]))
      else $error("pull-up write not applied");
   a_pullup_c: assert property (pur_c_we |=> port_c_bit0_pu == $past(port_c_pullup_enable[0]))
      else $error("shared pad pull-up write not applied");
   a_reset_def: assert property ($rose(rstn) |-> pu4 == 4'hF && pha_fn == (LARGE_VARIANT ? SPM_FN_PHASE : SPM_FN_NONE))
      else $error("reset defaults wrong");
   a_alt_sclk: assert property (s_alt_set |=> pha_fn == SPM_FN_SCLK)
      else $error("alternate select ignored");
endmodule
bind spm_pad_mux spm_pad_mux_checker #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (.*);

// file: tb/spm_spi_peer.sv
// external serial device on the four port0 pads
`timescale 1ns/1ps
module spm_spi_peer (
   // mux pad side
   input wire logic [3:0] pad_o,
   input wire logic [3:0] pad_oe,
   input wire logic [3:0] pad_pu,
   // peer drive
   input wire logic [3:0] peer_oe,
   input wire logic [3:0] peer_val,
   output logic [3:0] pad_lvl
);
   // pads driven by neither side read 1 when pulled up, else the inverse of pad_o
   assign pad_lvl = (pad_oe & pad_o) | (~pad_oe & peer_oe & peer_val) | (~pad_oe & ~peer_oe & (pad_pu | ~pad_o));
endmodule

// file: tb/test_spm_pad_mux.sv
// testbench for the serial port pad multiplexer
`timescale 1ns/1ps
module test_spm_pad_mux
   import spm_pkg::*;
;
   logic mclk = '0, rstn = '0, cfg_we = '0, pur_e_we = '0, pur_c_we = '0, alt_we = '0, tmr_sel_we = '0, tmr_sel = '0;
   logic phase_a_alternate_select = '0, gpio_c0_oe = '0, gpio_c0_out = '0, spi1_master = '0, spi1_sclk_out = '0;
   logic spi0_master = '1, spi0_sclk_out = '1, spi0_mosi_out = '0, spi0_miso_out = '1, port_c_bit0_i = '1;
   logic timer_b_channel0_oe = '0, timer_b_channel0_out = '0;
   logic [7:0] cfg_port_e_gpio_sel = '0, port_e_pullup_enable = '0, port_c_pullup_enable = '0;
   logic [3:0] gpio_e_oe = '0, gpio_e_out = '0, peer_oe = '0, peer_val = '0, gpio_e_in, lvl;
   logic gpio_c0_in, spi0_sclk_in, spi0_mosi_in, spi0_miso_in, spi0_selected, spi1_sclk_in, decoder1_phase_a;
   logic timer_b_channel0_in, port_c_bit0_o, port_c_bit0_oe, port_c_bit0_pu;
   logic port0_serial_clock_i, port0_serial_clock_o, port0_serial_clock_oe, port0_serial_clock_pu;
   logic port0_master_out_i, port0_master_out_o, port0_master_out_oe, port0_master_out_pu;
   logic port0_master_in_i, port0_master_in_o, port0_master_in_oe, port0_master_in_pu;
   logic port0_slave_select_n_i, port0_slave_select_n_o, port0_slave_select_n_oe, port0_slave_select_n_pu;
   spm_fn_t pha_fn;
   int n_errors = 0, total_checks = 0;
   wire [3:0] oe4 = {port0_slave_select_n_oe, port0_master_in_oe, port0_master_out_oe, port0_serial_clock_oe};
   wire [3:0] pu4 = {port0_slave_select_n_pu, port0_master_in_pu, port0_master_out_pu, port0_serial_clock_pu};
   wire [3:0] o4 = {port0_slave_select_n_o, port0_master_in_o, port0_master_out_o, port0_serial_clock_o};
   assign {port0_slave_select_n_i, port0_master_in_i, port0_master_out_i, port0_serial_clock_i} = lvl;
   spm_pad_mux #(.LARGE_VARIANT(1'b1)) uut (.*);
   spm_spi_peer peer (.pad_o(o4), .pad_oe(oe4), .pad_pu(pu4), .peer_oe(peer_oe), .peer_val(peer_val), .pad_lvl(lvl));
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(ref logic we);
      @(negedge mclk) we = 1'b1;
      @(negedge mclk) we = 1'b0;
   endtask
   task automatic t_reset();
      chk(pu4, 8'h0F);
      chk(port_c_bit0_pu, 8'h01);
      chk(pha_fn, SPM_FN_PHASE);
      chk(oe4, 8'h03);
      chk(o4[1:0], 8'h01);
      chk({port_c_bit0_oe, spi0_miso_in, spi0_selected}, 8'h02);
      chk({decoder1_phase_a, timer_b_channel0_in, spi1_sclk_in, gpio_c0_in}, 8'h09);
   endtask
   task automatic t_slave();
      @(negedge mclk) {spi0_master, peer_oe, peer_val} = {1'b0, 4'hF, 4'h9};
      @(posedge mclk) chk(oe4, 8'h00);
      chk({spi0_mosi_in, spi0_sclk_in}, 8'h01);
      @(negedge mclk) {peer_oe, peer_val} = {4'hB, 4'h2};
      @(posedge mclk) chk(spi0_selected, 8'h01);
      chk(oe4, 8'h04);
      chk(lvl[2], 8'h01);
      chk({spi0_mosi_in, spi0_sclk_in}, 8'h02);
   endtask
   task automatic t_gpio();
      @(negedge mclk) {cfg_port_e_gpio_sel, gpio_e_oe, gpio_e_out, peer_oe, peer_val} = {8'hF0, 4'h6, 4'h4, 4'h9, 4'h8};
      wr(cfg_we);
      chk(oe4, 8'h06);
      chk(o4 & oe4, 8'h04);
      chk(gpio_e_in, 8'h0C);
      chk({spi0_miso_in, spi0_mosi_in, spi0_sclk_in}, 8'h00);
      @(negedge mclk) cfg_port_e_gpio_sel = 8'h00;
      wr(cfg_we);
   endtask
   task automatic t_pull();
      @(negedge mclk) {port_e_pullup_enable, port_c_pullup_enable} = {8'h5A, 8'hFE};
      wr(pur_e_we);
      wr(pur_c_we);
      chk(pu4, 8'h05);
      chk(port_c_bit0_pu, 8'h00);
   endtask
   task automatic t_alt();
      @(negedge mclk) {timer_b_channel0_oe, timer_b_channel0_out, tmr_sel} = 3'h7;
      wr(tmr_sel_we);
      chk(pha_fn, SPM_FN_TIMER);
      chk({port_c_bit0_oe, port_c_bit0_o}, 8'h03);
      chk({timer_b_channel0_in, decoder1_phase_a}, 8'h02);
      @(negedge mclk) {spi1_master, spi1_sclk_out, phase_a_alternate_select} = 3'h5;
      wr(alt_we);
      chk(pha_fn, SPM_FN_SCLK);
      chk({port_c_bit0_oe, port_c_bit0_o}, 8'h02);
      chk({spi1_sclk_in, timer_b_channel0_in}, 8'h02);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge mclk);
      rstn = 1'b1;
      @(negedge mclk);
      t_reset();
      t_slave();
      t_gpio();
      t_pull();
      t_alt();
      final_report();
   end
endmodule
